/* File: logic/tcs_pkg.sv */
package tcs_pkg;

	// Register addresses (byte bus)
	localparam logic [15:0] ADDR_INSW    = 16'hff4f;
	localparam logic [15:0] ADDR_PRESCL  = 16'hffbb;
	localparam logic [15:0] ADDR_P3DIR   = 16'hff23;

	// Reset values
	localparam logic [7:0] RST_INSW   = 8'h00;
	localparam logic [7:0] RST_PRESCL = 8'h00;
	localparam logic [7:0] RST_P3DIR  = 8'hff;

	// Writable masks: fixed bits read as documented
	localparam logic [7:0] MASK_INSW   = 8'h3f;
	localparam logic [7:0] MASK_PRESCL = 8'hf7;
	localparam logic [7:0] MASK_P3DIR  = 8'h1e;
	localparam logic [7:0] FIX_P3DIR   = 8'he1;

	// Input switch field positions
	localparam int INSW_EXT_INT0_SRC = 0;
	localparam int INSW_CAPA_SRC     = 1;
	localparam int INSW_AUX_GATE     = 2;
	localparam int INSW_ALT_RX_EN    = 3;
	localparam int INSW_PIN_SEL_LO   = 4;
	localparam int INSW_PIN_SEL_HI   = 5;

	// Port 3 pin positions
	localparam int P3_PIN3 = 3;
	localparam int P3_PIN4 = 4;

	// Count clock select field
	localparam int CCS_LSB = 0;
	localparam int CCS_W   = 3;
	localparam int ES0_LSB = 4; // Capture-A edge select field
	localparam logic [2:0] CCS_PRS      = 3'h0;
	localparam logic [2:0] CCS_DIV2     = 3'h1;
	localparam logic [2:0] CCS_DIV4     = 3'h2;
	localparam logic [2:0] CCS_DIV16    = 3'h3;
	localparam logic [2:0] CCS_DIV256   = 3'h4;
	localparam logic [2:0] CCS_SUB      = 3'h5;
	localparam logic [2:0] CCS_CAPA     = 3'h6;
	localparam logic [2:0] CCS_AUX      = 3'h7;

	// Serial-6 pin placement codes
	localparam logic [1:0] S6_PINS_112 = 2'h0;
	localparam logic [1:0] S6_PINS_13  = 2'h2;

	// Prescaler width (divide by 256)
	localparam int PRE_W = 8;

	// Byte register bus request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        bit_op;
		logic [2:0]  bit_idx;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} tcs_bus_req_t;

	// Serial-6 pin set
	typedef struct packed {
		logic p112;
		logic p113;
		logic p13;
		logic p12;
	} tcs_s6_pins_t;

endpackage : tcs_pkg

/* File: logic/tcs_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser; change accepted once stages two and three agree
module tcs_sync (
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_b_i,
	// Data
	input  wire logic d_i,
	output logic      q_o,
	output logic      rise_o,
	output logic      fall_o
);

	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic q_r;

	// Shift chain; only s2 reads s1
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Filtered level; one-sample glitches are dropped
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q_r <= 1'b0;
		end else if (s2_r == s3_r) begin
			q_r <= s3_r;
		end
	end

	assign q_o    = q_r;
	assign rise_o = (s2_r == s3_r) && s3_r && !q_r;
	assign fall_o = (s2_r == s3_r) && !s3_r && q_r;

endmodule : tcs_sync
`default_nettype wire

/* File: logic/tcs_clock_select.sv */
`timescale 1ns/10ps
`default_nettype none

module tcs_clock_select (
	// Clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  rst_b_i,
	// Register access
	input  wire tcs_pkg::tcs_bus_req_t bus_i,
	output logic [7:0]                 rdata_o,
	output logic                       rvalid_o,
	// Timer mode (00 stopped)
	input  wire logic [1:0]            timer_op_mode_i,
	// Clock sources
	input  wire logic                  sub_clk_i,
	input  wire logic                  aux_timer_out_i,
	input  wire logic                  gating_timer_out_i,
	// Pins
	input  wire logic                  port3_pin3_i,
	input  wire logic                  port3_pin4_i,
	input  wire logic                  ext_interrupt0_pin_i,
	input  wire tcs_pkg::tcs_s6_pins_t s6_pins_i,
	input  wire logic                  serial6_transmit_i,
	input  wire logic [7:0]            port3_latch_i,
	input  wire logic                  timer_output_i,
	// Routed outputs
	output logic                       count_en_o,
	output logic                       capture_input_a_o,
	output logic                       capture_a_edge_o,
	output logic                       ext_interrupt0_o,
	output logic                       serial6_receive_o,
	output logic                       aux_timer_input_o,
	output tcs_pkg::tcs_s6_pins_t      s6_pins_o,
	output tcs_pkg::tcs_s6_pins_t      s6_pins_oe_o,
	output logic [7:0]                 port3_o,
	output logic [7:0]                 port3_oe_o,
	output logic [7:0]                 port3_direction_o
);
	import tcs_pkg::*;

	logic [7:0]       insw_r;
	logic [7:0]       prescl_r;
	logic [7:0]       p3dir_r;
	logic [7:0]       rdata_r;
	logic             rvalid_r;
	logic [PRE_W-1:0] pre_r;
	logic [PRE_W-1:0] pre_nxt;
	logic [2:0]       sel_r;
	logic             count_en_nxt;
	logic             s6_rx_raw;
	logic             capa_raw;
	logic             int0_raw;
	logic             capa_lvl;
	logic             capa_rise;
	logic             capa_fall;
	logic             int0_lvl;
	logic             sub_rise;
	logic             aux_rise;
	logic             gate_lvl;
	logic [1:0]       edge_sel;
	logic             capa_edge;
	logic             p4_in;

	// Merge a byte or one-bit write into a register
	function automatic logic [7:0] wr_merge(
		input logic [7:0]   cur,
		input tcs_bus_req_t req,
		input logic [7:0]   mask,
		input logic [7:0]   fixed
	);
		logic [7:0] v;
		v = cur;
		if (req.bit_op) begin
			v[req.bit_idx] = req.wdata[0];
		end else begin
			v = req.wdata;
		end
		wr_merge = (v & mask) | fixed;
	endfunction : wr_merge

	// Address hit for a write
	function automatic logic wr_hit(
		input tcs_bus_req_t req,
		input logic [15:0]  addr
	);
		wr_hit = req.wr && (req.addr == addr);
	endfunction : wr_hit

	// Input switch register
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			insw_r <= RST_INSW;
		end else if (wr_hit(bus_i, ADDR_INSW)) begin
			insw_r <= wr_merge(insw_r, bus_i, MASK_INSW, 8'h00);
		end
	end

	// Prescaler register; writes only land while the timer is stopped
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prescl_r <= RST_PRESCL;
		end else if (wr_hit(bus_i, ADDR_PRESCL) && timer_op_mode_i == 2'h0) begin
			prescl_r <= wr_merge(prescl_r, bus_i, MASK_PRESCL, 8'h00);
		end
	end

	// Port 3 direction; bits 7..5 and 0 read fixed at one
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			p3dir_r <= RST_P3DIR;
		end else if (wr_hit(bus_i, ADDR_P3DIR)) begin
			p3dir_r <= wr_merge(p3dir_r, bus_i, MASK_P3DIR, FIX_P3DIR);
		end
	end

	// Read port; unmapped reads give zero
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= bus_i.rd;
			case (bus_i.addr)
				ADDR_INSW:   rdata_r <= insw_r;
				ADDR_PRESCL: rdata_r <= prescl_r;
				ADDR_P3DIR:  rdata_r <= p3dir_r;
				default:     rdata_r <= 8'h00;
			endcase
		end
	end

	assign rdata_o           = rdata_r;
	assign rvalid_o          = rvalid_r;
	assign port3_direction_o = p3dir_r;

	// Serial-6 receive pin follows the placement field
	always_comb begin
		case (insw_r[INSW_PIN_SEL_HI:INSW_PIN_SEL_LO])
			S6_PINS_13: s6_rx_raw = s6_pins_i.p12;
			default:    s6_rx_raw = s6_pins_i.p113 & insw_r[INSW_ALT_RX_EN];
		endcase
	end

	// Transmit placement; receive pins are never driven
	always_comb begin
		s6_pins_o    = '0;
		s6_pins_oe_o = '0;
		if (insw_r[INSW_PIN_SEL_HI:INSW_PIN_SEL_LO] == S6_PINS_13) begin
			s6_pins_o.p13    = serial6_transmit_i;
			s6_pins_oe_o.p13 = 1'b1;
		end else begin
			s6_pins_o.p112    = serial6_transmit_i;
			s6_pins_oe_o.p112 = 1'b1;
		end
	end

	// Source routing for capture A and interrupt 0
	assign capa_raw = insw_r[INSW_CAPA_SRC] ? s6_rx_raw : port3_pin3_i;
	assign int0_raw = insw_r[INSW_EXT_INT0_SRC] ? s6_rx_raw
	                                            : ext_interrupt0_pin_i;

	// Pin inputs cross into the clock domain
	tcs_sync u_sync_capa (
		.mclk_i (mclk_i),
		.rst_b_i(rst_b_i),
		.d_i    (capa_raw),
		.q_o    (capa_lvl),
		.rise_o (capa_rise),
		.fall_o (capa_fall)
	);

	tcs_sync u_sync_int0 (
		.mclk_i (mclk_i),
		.rst_b_i(rst_b_i),
		.d_i    (int0_raw),
		.q_o    (int0_lvl),
		.rise_o (),
		.fall_o ()
	);

	tcs_sync u_sync_sub (
		.mclk_i (mclk_i),
		.rst_b_i(rst_b_i),
		.d_i    (sub_clk_i),
		.q_o    (),
		.rise_o (sub_rise),
		.fall_o ()
	);

	tcs_sync u_sync_gate (
		.mclk_i (mclk_i),
		.rst_b_i(rst_b_i),
		.d_i    (gating_timer_out_i),
		.q_o    (gate_lvl),
		.rise_o (),
		.fall_o ()
	);

	// Same-clock auxiliary timer output: plain edge detect
	logic aux_d_r;
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aux_d_r <= 1'b0;
		end else begin
			aux_d_r <= aux_timer_out_i;
		end
	end
	assign aux_rise = aux_timer_out_i && !aux_d_r;

	// Capture-A valid edge per the edge-select field
	assign edge_sel  = prescl_r[ES0_LSB +: 2];
	always_comb begin
		case (edge_sel)
			2'h0:    capa_edge = capa_fall;
			2'h1:    capa_edge = capa_rise;
			2'h3:    capa_edge = capa_rise | capa_fall;
			default: capa_edge = 1'b0;
		endcase
	end

	// Free-running prescaler
	assign pre_nxt = pre_r + PRE_W'(1);
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_nxt;
		end
	end

	// Selection is registered so the mux never changes mid-enable
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sel_r <= CCS_PRS;
		end else begin
			sel_r <= prescl_r[CCS_LSB +: CCS_W];
		end
	end

	// Enable pulse per source; divider ticks on wrap of its bits
	always_comb begin
		case (sel_r)
			CCS_PRS:    count_en_nxt = 1'b1;
			CCS_DIV2:   count_en_nxt = (pre_r[0] == 1'b1);
			CCS_DIV4:   count_en_nxt = (pre_r[1:0] == 2'h3);
			CCS_DIV16:  count_en_nxt = (pre_r[3:0] == 4'hf);
			CCS_DIV256: count_en_nxt = (pre_r == 8'hff);
			CCS_SUB:    count_en_nxt = sub_rise;
			CCS_CAPA:   count_en_nxt = capa_edge;
			CCS_AUX:    count_en_nxt = aux_rise;
			default:    count_en_nxt = 1'b0;
		endcase
	end

	// Registered one-cycle enable to the counter
	logic count_en_r;
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count_en_r <= 1'b0;
		end else begin
			count_en_r <= count_en_nxt;
		end
	end

	assign count_en_o        = count_en_r;
	assign capture_input_a_o = capa_lvl;
	assign capture_a_edge_o  = capa_edge;
	assign ext_interrupt0_o  = int0_lvl;
	assign serial6_receive_o = s6_rx_raw;

	// Auxiliary timer input on pin 34, gated when enabled
	assign p4_in = p3dir_r[P3_PIN4] ? port3_pin4_i : 1'b0;
	assign aux_timer_input_o = insw_r[INSW_AUX_GATE] ? (p4_in & gate_lvl)
	                                                 : p4_in;

	// Port 3 drivers: direction 0 enables the buffer
	always_comb begin
		port3_o    = port3_latch_i;
		port3_oe_o = ~p3dir_r;
		port3_o[P3_PIN4] = port3_latch_i[P3_PIN4] | timer_output_i;
	end

endmodule : tcs_clock_select
`default_nettype wire

/* File: test/tcs_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Far side: free subclock, aux timer output and a slow toggling pin
module tcs_pin_model #(
	parameter int SUB_HALF_NS = 15259 // Near 32.768 kHz
) (
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_b_i,
	// High: serial receive toggles and pin 3 rests high
	input  wire logic src_rx_i,
	// Pin levels
	output logic      sub_clk_o,
	output logic      aux_out_o,
	output logic      pin3_o,
	output logic      p12_o
);
	logic [3:0] cnt_r;

	// Crystal subclock runs free, unrelated to mclk
	initial begin
		sub_clk_o = 1'b0;
		forever #(SUB_HALF_NS) sub_clk_o = ~sub_clk_o;
	end

	// Levels change just after the falling edge
	always_ff @(negedge mclk_i) begin
		if (!rst_b_i) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	// Each level lasts 8 periods, well above the filter minimum
	assign aux_out_o = rst_b_i & cnt_r[3];
	assign pin3_o = src_rx_i | (rst_b_i & cnt_r[3]);
	assign p12_o = !src_rx_i | cnt_r[3];
endmodule : tcs_pin_model
`default_nettype wire

/* File: test/tcs_clock_select_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

// Port checks on the selector and the pin routing
module tcs_clock_select_monitor (
	// Clock and reset
	input wire logic                  mclk_i,
	input wire logic                  rst_b_i,
	// Block inputs
	input wire tcs_pkg::tcs_bus_req_t bus_i,
	input wire logic [1:0]            timer_op_mode_i,
	input wire logic                  port3_pin3_i,
	input wire logic                  port3_pin4_i,
	input wire tcs_pkg::tcs_s6_pins_t s6_pins_i,
	// Block outputs
	input wire logic                  count_en_o,
	input wire logic                  capture_a_edge_o,
	input wire logic                  capture_input_a_o,
	input wire logic                  ext_interrupt0_o,
	input wire logic                  serial6_receive_o,
	input wire logic                  aux_timer_input_o,
	input wire logic [7:0]            port3_oe_o,
	input wire logic [7:0]            port3_direction_o
);
	import tcs_pkg::*;
	logic [7:0] sw_r;
	logic [2:0] ccs_r;

	// Shadow of the switch register, bit and byte writes
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sw_r <= RST_INSW;
		end else if (bus_i.wr && bus_i.addr == ADDR_INSW) begin
			if (bus_i.bit_op) begin
				sw_r[bus_i.bit_idx] <= bus_i.wdata[0];
			end else begin
				sw_r <= bus_i.wdata;
			end
		end
	end

	// Selector shadow; bench uses byte writes only here
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ccs_r <= RST_PRESCL[2:0];
		end else if (bus_i.wr && !bus_i.bit_op && timer_op_mode_i == 2'h0
				&& bus_i.addr == ADDR_PRESCL) begin
			ccs_r <= bus_i.wdata[2:0];
		end
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);

	chk_dir_reset_val: assert property (disable iff (1'b0)
		!rst_b_i |-> port3_direction_o == RST_P3DIR)
		else $error("direction reset value");
	chk_dir_byte_wr: assert property (
		bus_i.wr && !bus_i.bit_op && bus_i.addr == ADDR_P3DIR |=>
		port3_direction_o ==
		(($past(bus_i.wdata) & MASK_P3DIR) | FIX_P3DIR))
		else $error("direction write");
	chk_oe_from_dir: assert property (
		port3_oe_o == ~port3_direction_o) else $error("output enable");
	chk_rx_pin_hi: assert property (
		sw_r[5:4] == S6_PINS_13 |-> serial6_receive_o == s6_pins_i.p12)
		else $error("receive pin");
	chk_capa_from_pin: assert property (
		(!sw_r[1] && $stable(port3_pin3_i))[*6] |->
		capture_input_a_o == port3_pin3_i) else $error("capture route");
	chk_int0_from_rx: assert property (
		(sw_r[0] && sw_r[5:4] == S6_PINS_13 && $stable(s6_pins_i.p12))[*6]
		|-> ext_interrupt0_o == s6_pins_i.p12) else $error("int0 route");
	chk_div2_alt: assert property (
		(ccs_r == CCS_DIV2)[*4] |-> count_en_o != $past(count_en_o))
		else $error("divide by two");
	chk_capa_edge_en: assert property (
		(ccs_r == CCS_CAPA)[*2] |=>
		count_en_o == $past(capture_a_edge_o))
		else $error("capture edge enable");
	chk_aux_ungated: assert property (
		!sw_r[2] |-> aux_timer_input_o ==
		(port3_pin4_i & port3_direction_o[P3_PIN4]))
		else $error("aux input");
endmodule : tcs_clock_select_monitor

bind tcs_clock_select tcs_clock_select_monitor u_mon (
	.mclk_i, .rst_b_i, .bus_i, .timer_op_mode_i, .port3_pin3_i,
	.port3_pin4_i, .s6_pins_i, .count_en_o, .capture_a_edge_o,
	.capture_input_a_o,
	.ext_interrupt0_o, .serial6_receive_o, .aux_timer_input_o,
	.port3_oe_o, .port3_direction_o
);
`default_nettype wire

/* File: test/tcs_clock_select_tb.sv */
`timescale 1ns/10ps
`default_nettype none

// Self-checking bench for the clock selector and routing
module tcs_clock_select_tb;
	import tcs_pkg::*;
	logic         mclk_i;
	logic         rst_b_i;
	tcs_bus_req_t bus_i;
	logic [7:0]   rdata_o;
	logic         rvalid_o;
	logic [1:0]   timer_op_mode_i;
	logic         sub_clk_i;
	logic         aux_timer_out_i;
	logic         port3_pin3_i;
	logic         p12;
	logic         src_rx;
	tcs_s6_pins_t s6_pins_i;
	logic [7:0]   port3_latch_i;
	logic         timer_output_i;
	logic         gate_in;
	logic         p4_pin;
	logic         int0_pin;
	logic         s6_tx;
	logic         aux_timer_input_o;
	logic         ext_interrupt0_o;
	tcs_s6_pins_t s6_pins_o;
	tcs_s6_pins_t s6_pins_oe_o;
	logic         count_en_o;
	logic [7:0]   port3_o;
	logic [7:0]   port3_oe_o;
	logic [7:0]   port3_direction_o;
	int           fail_count;
	int           cmp_count;

	// Unused serial pins rest high
	assign s6_pins_i = {3'b111, p12};

	tcs_clock_select DUT (
		.mclk_i, .rst_b_i, .bus_i, .rdata_o, .rvalid_o, .timer_op_mode_i,
		.sub_clk_i, .aux_timer_out_i, .gating_timer_out_i(gate_in),
		.port3_pin3_i, .port3_pin4_i(p4_pin),
		.ext_interrupt0_pin_i(int0_pin),
		.s6_pins_i, .serial6_transmit_i(s6_tx), .port3_latch_i,
		.timer_output_i, .count_en_o, .capture_input_a_o(),
		.capture_a_edge_o(), .ext_interrupt0_o, .serial6_receive_o(),
		.aux_timer_input_o, .s6_pins_o, .s6_pins_oe_o, .port3_o,
		.port3_oe_o, .port3_direction_o
	);
	tcs_pin_model PM (
		.mclk_i, .rst_b_i, .src_rx_i(src_rx), .sub_clk_o(sub_clk_i),
		.aux_out_o(aux_timer_out_i), .pin3_o(port3_pin3_i), .p12_o(p12)
	);

	// 250 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	task automatic cmp8(logic [7:0] g, logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : cmp8

	task automatic cmpn(int g, int e);
		cmp_count++;
		if (g != e) begin
			fail_count++;
			$display("MISMATCH t=%0t count %0d exp %0d", $time, g, e);
		end
	endtask : cmpn

	// One request for one cycle, then idle
	task automatic req(tcs_bus_req_t q);
		@(negedge mclk_i);
		bus_i = q;
		@(negedge mclk_i);
		bus_i = '0;
	endtask : req

	task automatic wr(logic [15:0] a, logic [7:0] d);
		req({3'b100, 3'h0, a, d});
	endtask : wr

	// Answer stands in the cycle after the request edge
	task automatic rd(logic [15:0] a, logic [7:0] e);
		req({3'b010, 3'h0, a, 8'h00});
		cmp8(rvalid_o === 1'b1 ? rdata_o : 8'hxx, e);
	endtask : rd

	// Whole source periods per window, so phase cannot change the count
	task automatic cnt(int n, int e);
		int c;
		c = 0;
		repeat (16) @(negedge mclk_i);
		repeat (n) begin
			@(negedge mclk_i);
			if (count_en_o === 1'b1) c++;
		end
		cmpn(c, e);
	endtask : cnt

	task automatic t_regs();
		rd(ADDR_INSW, RST_INSW);
		rd(ADDR_P3DIR, RST_P3DIR);
		req({3'b101, 3'h1, ADDR_INSW, 8'h01});
		rd(ADDR_INSW, 8'h02);
		wr(ADDR_INSW, 8'hff);
		rd(ADDR_INSW, MASK_INSW);
		rd(16'hff00, 8'h00);
		wr(ADDR_INSW, 8'h00);
		$display("test regs done");
	endtask : t_regs

	task automatic t_clk();
		int ex [8] = '{512, 256, 128, 32, 2, 4, 32, 32};
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_PRESCL, {5'h00, k[2:0]});
			cnt(k == 5 ? 30518 : 512, ex[k]);
		end
		$display("test clk done");
	endtask : t_clk

	task automatic t_route();
		logic [7:0] sw [3] = '{8'h23, 8'h20, 8'h02};
		int ex [3] = '{32, 0, 0};
		src_rx = 1'b1;
		wr(ADDR_PRESCL, {5'h00, CCS_CAPA});
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_INSW, sw[k]);
			cnt(512, ex[k]);
		end
		// Rising and both-edge selections on the routed receive pin
		wr(ADDR_INSW, 8'h23);
		wr(ADDR_PRESCL, 8'h16);
		cnt(512, 32);
		wr(ADDR_PRESCL, 8'h36);
		cnt(512, 64);
		$display("test route done");
	endtask : t_route

	// A running timer must leave the selector alone
	task automatic t_refuse();
		timer_op_mode_i = 2'h1;
		wr(ADDR_PRESCL, 8'h00);
		rd(ADDR_PRESCL, 8'h36);
		timer_op_mode_i = 2'h0;
		$display("test refuse done");
	endtask : t_refuse

	task automatic t_port();
		wr(ADDR_P3DIR, 8'h00);
		rd(ADDR_P3DIR, FIX_P3DIR);
		cmp8(port3_oe_o, ~FIX_P3DIR);
		port3_latch_i = 8'h00;
		timer_output_i = 1'b1;
		@(negedge mclk_i);
		cmp8({7'h00, port3_o[P3_PIN4]}, 8'h01);
		wr(ADDR_P3DIR, 8'hff);
		cmp8(port3_oe_o, 8'h00);
		$display("test port done");
	endtask : t_port

	// Transmit placement, interrupt pin route and pin-34 gating
	task automatic t_pins();
		s6_tx = 1'b1;
		int0_pin = 1'b1;
		wr(ADDR_INSW, 8'h20);
		repeat (6) @(negedge mclk_i);
		cmp8({4'h0, s6_pins_o}, 8'h02);
		cmp8({4'h0, s6_pins_oe_o}, 8'h02);
		cmp8({7'h00, ext_interrupt0_o}, 8'h01);
		wr(ADDR_INSW, 8'h04);
		repeat (6) @(negedge mclk_i);
		cmp8({4'h0, s6_pins_oe_o}, 8'h08);
		cmp8({7'h00, aux_timer_input_o}, 8'h00);
		gate_in = 1'b1;
		repeat (6) @(negedge mclk_i);
		cmp8({7'h00, aux_timer_input_o}, 8'h01);
		p4_pin = 1'b0;
		@(negedge mclk_i);
		cmp8({7'h00, aux_timer_input_o}, 8'h00);
		$display("test pins done");
	endtask : t_pins

	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	initial begin
		rst_b_i = 1'b1;
		bus_i = '0;
		s6_tx = 1'b0;
		int0_pin = 1'b0;
		gate_in = 1'b0;
		p4_pin = 1'b1;
		timer_op_mode_i = 2'h0;
		src_rx = 1'b0;
		port3_latch_i = 8'h00;
		timer_output_i = 1'b0;
		fail_count = 0;
		cmp_count = 0;
		// Drop reset off time zero so the async branches see a real edge
		#1;
		rst_b_i = 1'b0;
		repeat (5) @(negedge mclk_i);
		rst_b_i = 1'b1;
		t_regs();
		t_clk();
		t_route();
		t_refuse();
		t_port();
		t_pins();
		conclude();
	end

	// Run needs about 40000 cycles; allow half as much again
	initial begin
		#240000;
		fail_count++;
		conclude();
	end
endmodule : tcs_clock_select_tb
`default_nettype wire
